// File: rtl/l2_cache_regs.svh
`ifndef L2_CACHE_REGS_SVH
`define L2_CACHE_REGS_SVH

// bit positions count from the lsb; bit 0 of the control word is bit 31 here
`define L2C_EN_BIT 31
`define L2C_RAM_MSB 24
`define L2C_RAM_LSB 23
`define L2C_DO_BIT 22
`define L2C_INV_BIT 21
`define L2C_CTL_BIT 20
`define L2C_WT_BIT 19
`define L2C_TS_BIT 18
`define L2C_OH_MSB 17
`define L2C_OH_LSB 16
`define L2C_SL_BIT 15
`define L2C_IO_BIT 10
`define L2C_RESET 32'h0000_0000
`define L2C_WR_MASK 32'h81ff_8400
`define L2C_RAM_PIPELINED 2'b10
`define L2C_OH_0P8NS 2'b01

`endif

// File: rtl/l2_cache_pkg.sv
package l2_cache_pkg;

   typedef enum logic [2:0]
   {
      K_IFETCH = 3'b000,
      K_LOAD = 3'b001,
      K_STORE = 3'b010,
      K_STORE_SINGLE = 3'b011,
      K_PUSH = 3'b100,
      K_ZERO = 3'b101,
      K_CASTOUT = 3'b110
   } req_kind_e;

   typedef enum logic
   {
      BEAT_IDLE = 1'b0,
      BEAT_RUN = 1'b1
   } beat_state_e;

   typedef enum logic
   {
      INV_IDLE = 1'b0,
      INV_WALK = 1'b1
   } inv_state_e;

endpackage : l2_cache_pkg

// File: rtl/l2_status_array.sv
`timescale 1ns/1ps
module l2_status_array #(
   parameter int SETS = 16,
   parameter int IDX_W = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // lookup
   input wire logic [IDX_W-1:0] rd_idx,
   output logic rd_valid,
   output logic rd_dirty,
   // update
   input wire logic wr_en,
   input wire logic [IDX_W-1:0] wr_idx,
   input wire logic wr_valid,
   input wire logic wr_dirty,
   // global invalidate walk
   input wire logic inv_go,
   output logic inv_busy_q,
   output logic inv_last
);
   import l2_cache_pkg::*;

   inv_state_e state_q;
   logic [IDX_W-1:0] walk_q;
   logic [SETS-1:0] valid_q;
   logic [SETS-1:0] dirty_q;

   assign inv_last = (state_q == INV_WALK) && (walk_q == IDX_W'(SETS - 1));
   assign rd_valid = valid_q[rd_idx];
   assign rd_dirty = dirty_q[rd_idx];
   assign inv_busy_q = (state_q == INV_WALK);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= INV_IDLE;
         walk_q <= '0;
      end
      else
      begin
         case (state_q)
            INV_IDLE:
            begin
               if (inv_go)
               begin
                  state_q <= INV_WALK;
                  walk_q <= '0;
               end
            end
            INV_WALK:
            begin
               walk_q <= walk_q + 1'b1;
               if (inv_last)
               begin
                  state_q <= INV_IDLE;
               end
            end
            default:
            begin
               state_q <= INV_IDLE;
            end
         endcase
      end
   end

   // one set per cycle keeps the clear path as small as a normal write
   genvar g;
   generate
      for (g = 0; g < SETS; g++)
      begin : g_set
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               valid_q[g] <= 1'b0;
               dirty_q[g] <= 1'b0;
            end
            else if (state_q == INV_WALK && walk_q == IDX_W'(g))
            begin
               valid_q[g] <= 1'b0;
               dirty_q[g] <= 1'b0;
            end
            else if (wr_en && wr_idx == IDX_W'(g))
            begin
               valid_q[g] <= wr_valid;
               dirty_q[g] <= wr_dirty;
            end
         end
      end
   endgenerate

endmodule : l2_status_array

// File: rtl/l2_beat_addr.sv
`timescale 1ns/1ps
module l2_beat_addr #(
   parameter int IDX_W = 4,
   parameter int BEAT_W = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // line request
   input wire logic start,
   input wire logic [IDX_W-1:0] base_idx,
   // sram address side
   output logic [IDX_W+BEAT_W-1:0] sram_addr_q,
   output logic sram_strobe_q,
   output logic busy_q,
   output logic last
);
   import l2_cache_pkg::*;

   beat_state_e state_q;
   logic [BEAT_W-1:0] cnt_q;

   assign busy_q = (state_q == BEAT_RUN);
   assign last = busy_q && (cnt_q == {BEAT_W{1'b1}});

   // a fresh address with its own strobe on every beat, never a burst advance
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= BEAT_IDLE;
         cnt_q <= '0;
         sram_addr_q <= '0;
         sram_strobe_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            BEAT_IDLE:
            begin
               sram_strobe_q <= start;
               if (start)
               begin
                  state_q <= BEAT_RUN;
                  cnt_q <= '0;
                  sram_addr_q <= {base_idx, {BEAT_W{1'b0}}};
               end
            end
            BEAT_RUN:
            begin
               if (last)
               begin
                  state_q <= BEAT_IDLE;
                  sram_strobe_q <= 1'b0;
               end
               else
               begin
                  cnt_q <= cnt_q + 1'b1;
                  sram_addr_q <= sram_addr_q + 1'b1;
                  sram_strobe_q <= 1'b1;
               end
            end
            default:
            begin
               state_q <= BEAT_IDLE;
            end
         endcase
      end
   end

endmodule : l2_beat_addr

// File: rtl/l2_cache_mode_control.sv
`timescale 1ns/1ps
`include "l2_cache_regs.svh"

module l2_cache_mode_control #(
   parameter int SETS = 16,
   parameter int IDX_W = 4,
   parameter int BEAT_W = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // special register port
   input wire logic spr_wr_en,
   input wire logic [31:0] spr_wdata,
   output logic [31:0] spr_rdata_q,
   // l1 transaction request
   input wire logic req_valid,
   input wire l2_cache_pkg::req_kind_e req_kind,
   input wire logic [IDX_W-1:0] req_idx,
   input wire logic req_tag_match,
   output logic req_ready_q,
   // decision
   output logic resp_valid_q,
   output logic resp_hit_q,
   output logic resp_alloc_q,
   output logic resp_l2_write_q,
   output logic resp_dirty_q,
   output logic resp_bus_write_q,
   output logic resp_broadcast_q,
   // power state
   input wire logic nap_in,
   input wire logic sleep_in,
   output logic cache_ram_low_power_out_q,
   // sram and dll configuration
   output logic [IDX_W+BEAT_W-1:0] sram_addr_q,
   output logic sram_strobe_q,
   output logic sram_pipelined_q,
   output logic [1:0] output_hold_select_q,
   output logic hold_0p8ns_q,
   output logic dll_slow_taps_q,
   output logic invalidate_busy_q
);
   import l2_cache_pkg::*;

   localparam int INV_MAX = 40;

   logic [31:0] ctl_q;
   logic [31:0] ctl_d;
   wire en = ctl_q[`L2C_EN_BIT];
   wire data_only = ctl_q[`L2C_DO_BIT];
   wire instr_only = ctl_q[`L2C_IO_BIT];
   wire wt = ctl_q[`L2C_WT_BIT];
   wire ts = ctl_q[`L2C_TS_BIT];

   // only implemented fields store; other bits read as zero
   assign ctl_d = spr_wr_en ? (spr_wdata & `L2C_WR_MASK) : ctl_q;
   wire inv_go = spr_wr_en && spr_wdata[`L2C_INV_BIT] && !ctl_q[`L2C_INV_BIT];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctl_q <= `L2C_RESET;
      end
      else
      begin
         ctl_q <= ctl_d;
      end
   end

   assign spr_rdata_q = ctl_q;

   // status lookup and decision
   logic st_valid;
   logic inv_last;
   logic beat_busy;
   logic beat_last;
   wire accept = req_valid && req_ready_q;
   wire is_data = (req_kind != K_IFETCH);
   wire is_read = (req_kind == K_IFETCH) || (req_kind == K_LOAD);
   wire is_push = (req_kind == K_PUSH);
   wire is_single = (req_kind == K_STORE_SINGLE);
   wire is_write = (req_kind == K_STORE) || is_single || (req_kind == K_ZERO) ||
                   (req_kind == K_CASTOUT);
   // enable is sampled per request, so it takes hold on the next transaction
   wire hit = en && st_valid && req_tag_match;
   wire alloc_ok = en && !(data_only && instr_only)
                   && (!data_only || is_data)
                   && (!instr_only || !is_data);
   wire fill = !hit && alloc_ok && is_read;
   wire push_l2 = is_push && ts && (hit || alloc_ok);
   wire push_inval = is_push && !ts && hit;
   wire l2_write = (is_write && (hit || alloc_ok)) || push_l2;
   wire alloc = fill || (l2_write && !hit);
   wire single_miss_held = ts && is_single && !hit;
   wire bus_write = ((is_push && !ts)
                    || (is_write && !l2_write)
                    || (l2_write && wt && !is_push))
                    && !single_miss_held;
   wire broadcast = (req_kind == K_ZERO) && !ts;
   wire wr_dirty = l2_write && !wt;
   wire wr_en = accept && (alloc || l2_write || push_inval);
   wire needs_line = accept && (fill || l2_write || (hit && is_read));
   // back-to-back lines would merge strobes, so one idle cycle is kept between them
   wire ready_d = !needs_line && (!beat_busy || beat_last) && !inv_go &&
                  (!invalidate_busy_q || inv_last);

   l2_status_array #(
      .SETS(SETS),
      .IDX_W(IDX_W)
   ) l2_status_array_inst (
      .clk(clk),
      .rst_n(rst_n),
      .rd_idx(req_idx),
      .rd_valid(st_valid),
      .rd_dirty(),
      .wr_en(wr_en),
      .wr_idx(req_idx),
      .wr_valid(!push_inval),
      .wr_dirty(wr_dirty),
      .inv_go(inv_go),
      .inv_busy_q(invalidate_busy_q),
      .inv_last(inv_last)
   );

   l2_beat_addr #(
      .IDX_W(IDX_W),
      .BEAT_W(BEAT_W)
   ) l2_beat_addr_inst (
      .clk(clk),
      .rst_n(rst_n),
      .start(needs_line),
      .base_idx(req_idx),
      .sram_addr_q(sram_addr_q),
      .sram_strobe_q(sram_strobe_q),
      .busy_q(beat_busy),
      .last(beat_last)
   );

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         req_ready_q <= 1'b0;
         resp_valid_q <= 1'b0;
         resp_hit_q <= 1'b0;
         resp_alloc_q <= 1'b0;
         resp_l2_write_q <= 1'b0;
         resp_dirty_q <= 1'b0;
         resp_bus_write_q <= 1'b0;
         resp_broadcast_q <= 1'b0;
      end
      else
      begin
         req_ready_q <= ready_d;
         resp_valid_q <= accept;
         resp_hit_q <= accept && hit;
         resp_alloc_q <= accept && alloc;
         resp_l2_write_q <= accept && l2_write;
         resp_dirty_q <= accept && wr_dirty;
         resp_bus_write_q <= accept && bus_write;
         resp_broadcast_q <= accept && broadcast;
      end
   end

   // configuration outputs; the ram-sleep pin follows the power state only while the L2C_CTL_BIT field is set, whether or not the cache is enabled
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cache_ram_low_power_out_q <= 1'b0;
         sram_pipelined_q <= 1'b0;
         output_hold_select_q <= 2'b00;
         hold_0p8ns_q <= 1'b0;
         dll_slow_taps_q <= 1'b0;
      end
      else
      begin
         cache_ram_low_power_out_q <= ctl_q[`L2C_CTL_BIT] && (nap_in || sleep_in);
         sram_pipelined_q <= (ctl_q[`L2C_RAM_MSB:`L2C_RAM_LSB] == `L2C_RAM_PIPELINED);
         output_hold_select_q <= ctl_q[`L2C_OH_MSB:`L2C_OH_LSB];
         hold_0p8ns_q <= (ctl_q[`L2C_OH_MSB:`L2C_OH_LSB] == `L2C_OH_0P8NS);
         dll_slow_taps_q <= ctl_q[`L2C_SL_BIT];
      end
   end

   // checks
   sequence s_four_beats;
      sram_strobe_q [*4];
   endsequence

   sequence s_walk_done;
      invalidate_busy_q ##[1:INV_MAX] !invalidate_busy_q;
   endsequence

   a_ram_type_out: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 sram_pipelined_q == ($past(ctl_q[24:23]) == 2'b10))
      else $error("sram type output does not follow the type field");

   a_beat_each_addr: assert property (@(posedge clk) disable iff (!rst_n)
      needs_line |=> s_four_beats ##1 !sram_strobe_q)
      else $error("line transfer is not four single-address beats");

   a_beat_addr_step: assert property (@(posedge clk) disable iff (!rst_n)
      sram_strobe_q && $past(sram_strobe_q) |-> sram_addr_q == $past(sram_addr_q) + 1'b1)
      else $error("sram address did not advance by one per beat");

   a_data_only_alloc: assert property (@(posedge clk) disable iff (!rst_n)
      accept && data_only && !is_data |=> !resp_alloc_q)
      else $error("instruction miss allocated in data-only mode");

   a_ifetch_hit_kept: assert property (@(posedge clk) disable iff (!rst_n)
      accept && data_only && hit |=> resp_hit_q)
      else $error("instruction hit not served in data-only mode");

   a_locked_no_alloc: assert property (@(posedge clk) disable iff (!rst_n)
      accept && data_only && instr_only |=> !resp_alloc_q)
      else $error("allocation while cache is locked");

   a_invalidate_walk: assert property (@(posedge clk) disable iff (!rst_n)
      inv_go |=> s_walk_done)
      else $error("global invalidate did not run and finish in time");

   a_sleep_follows: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 cache_ram_low_power_out_q == $past(ctl_q[20] && (nap_in || sleep_in)))
      else $error("low-power output does not track nap or sleep");

   a_wt_clean_bus: assert property (@(posedge clk) disable iff (!rst_n)
      accept && wt && l2_write && !is_push |=> resp_bus_write_q && !resp_dirty_q)
      else $error("write-through write not sent on or marked dirty");

   a_ts_push_local: assert property (@(posedge clk) disable iff (!rst_n)
      accept && ts && is_push |=> !resp_bus_write_q)
      else $error("test-support push reached the system bus");

   a_ts_quiet_bus: assert property (@(posedge clk) disable iff (!rst_n)
      accept && ts && (req_kind == K_ZERO || single_miss_held)
      |=> !resp_broadcast_q && !resp_bus_write_q)
      else $error("test support let zero or single-beat miss onto the bus");

   a_disabled_idle: assert property (@(posedge clk) disable iff (!rst_n)
      accept && !en |=> !resp_hit_q && !resp_alloc_q && !resp_l2_write_q)
      else $error("disabled cache hit or allocated");

   a_read_back: assert property (@(posedge clk) disable iff (!rst_n)
      spr_wr_en |=> spr_rdata_q == ($past(spr_wdata) & 32'h81ff_8400))
      else $error("control register read-back mismatch");

   a_hold_copy: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 output_hold_select_q == $past(ctl_q[`L2C_OH_MSB:`L2C_OH_LSB]))
      else $error("hold select output does not follow the hold field");

   a_hold_0p8: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 hold_0p8ns_q == ($past(ctl_q[`L2C_OH_MSB:`L2C_OH_LSB]) == `L2C_OH_0P8NS))
      else $error("short hold flag does not match the hold field");

   a_dll_slow_copy: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 dll_slow_taps_q == $past(ctl_q[`L2C_SL_BIT]))
      else $error("dll slow output does not follow its bit");

   a_line_ready_low: assert property (@(posedge clk) disable iff (!rst_n)
      needs_line |=> !req_ready_q)
      else $error("request taken while a line transfer starts");

   a_walk_no_ready: assert property (@(posedge clk) disable iff (!rst_n)
      invalidate_busy_q && !inv_last |=> !req_ready_q)
      else $error("request port open during invalidate walk");

   a_wt_bus_on: assert property (@(posedge clk) disable iff (!rst_n)
      accept && wt && !ts && is_write && (hit || alloc_ok) |=> resp_l2_write_q && resp_bus_write_q)
      else $error("write-through cache write not sent to the bus");

   a_push_plain: assert property (@(posedge clk) disable iff (!rst_n)
      accept && !ts && is_push |=> resp_bus_write_q && !resp_l2_write_q)
      else $error("plain push did not go only to the bus");

   a_ts_push_kept: assert property (@(posedge clk) disable iff (!rst_n)
      accept && ts && is_push && hit |=> resp_l2_write_q)
      else $error("test-support push hit not written into the cache");

   a_data_alloc: assert property (@(posedge clk) disable iff (!rst_n)
      accept && en && data_only && !instr_only && req_kind == K_LOAD && !hit |=> resp_alloc_q)
      else $error("data miss not allocated in data-only mode");

endmodule : l2_cache_mode_control

// File: sim/sram_model.sv
`timescale 1ns/1ps
module sram_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // sram address side
   input wire logic [5:0] sram_addr_q,
   input wire logic sram_strobe_q
);
   logic [5:0] log_q [$];
   logic last_strobe_q;
   logic [5:0] last_addr_q;
   int faults;
   // register-register part: it latches an address on every strobe and has no
   // burst counter of its own, so two back-to-back strobed beats on one address are a fault
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         last_strobe_q <= 1'b0;
         last_addr_q <= 6'h00;
      end
      else
      begin
         if (sram_strobe_q)
         begin
            log_q.push_back(sram_addr_q);
            if (last_strobe_q && sram_addr_q === last_addr_q) faults++;
         end
         last_strobe_q <= sram_strobe_q;
         last_addr_q <= sram_addr_q;
      end
   end
endmodule : sram_model

// File: sim/l2_cache_mode_control_tb.sv
`timescale 1ns/1ps
`include "l2_cache_regs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module l2_cache_mode_control_tb;
   import l2_cache_pkg::*;
   localparam logic [31:0] EN = 32'h8000_0000;
   localparam logic [31:0] DO = 32'h0040_0000;
   localparam logic [31:0] INV = 32'h0020_0000;
   localparam logic [31:0] CTL = 32'h0010_0000;
   localparam logic [31:0] WT = 32'h0008_0000;
   localparam logic [31:0] TS = 32'h0004_0000;
   localparam logic [31:0] IO = 32'h0000_0400;
   localparam logic [5:0] H = 6'h20, A = 6'h10, W = 6'h08, D = 6'h04, B = 6'h02, Z = 6'h01;
   logic clk, rst_n, spr_wr_en, req_valid, req_tag_match, nap_in, sleep_in;
   logic [31:0] spr_wdata, spr_rdata_q;
   req_kind_e req_kind;
   logic [3:0] req_idx;
   logic req_ready_q, resp_valid_q, resp_hit_q, resp_alloc_q, resp_l2_write_q;
   logic resp_dirty_q, resp_bus_write_q, resp_broadcast_q, cache_ram_low_power_out_q;
   logic [5:0] sram_addr_q;
   logic sram_strobe_q, sram_pipelined_q, hold_0p8ns_q, dll_slow_taps_q, invalidate_busy_q;
   logic [1:0] output_hold_select_q;
   int num_errors = 0;
   int checks = 0;
   int n;
   l2_cache_mode_control l2_cache_mode_control_inst (.clk(clk), .rst_n(rst_n),
      .spr_wr_en(spr_wr_en), .spr_wdata(spr_wdata), .spr_rdata_q(spr_rdata_q),
      .req_valid(req_valid), .req_kind(req_kind), .req_idx(req_idx),
      .req_tag_match(req_tag_match), .req_ready_q(req_ready_q),
      .resp_valid_q(resp_valid_q), .resp_hit_q(resp_hit_q), .resp_alloc_q(resp_alloc_q),
      .resp_l2_write_q(resp_l2_write_q), .resp_dirty_q(resp_dirty_q),
      .resp_bus_write_q(resp_bus_write_q), .resp_broadcast_q(resp_broadcast_q),
      .nap_in(nap_in), .sleep_in(sleep_in),
      .cache_ram_low_power_out_q(cache_ram_low_power_out_q),
      .sram_addr_q(sram_addr_q), .sram_strobe_q(sram_strobe_q),
      .sram_pipelined_q(sram_pipelined_q), .output_hold_select_q(output_hold_select_q),
      .hold_0p8ns_q(hold_0p8ns_q), .dll_slow_taps_q(dll_slow_taps_q),
      .invalidate_busy_q(invalidate_busy_q));
   sram_model sram_model_inst (.clk(clk), .rst_n(rst_n), .sram_addr_q(sram_addr_q),
      .sram_strobe_q(sram_strobe_q));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task complete_run;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   task wr_only(input logic [31:0] w);
      spr_wr_en = 1'b1;
      spr_wdata = w;
      @(negedge clk);
      spr_wr_en = 1'b0;
   endtask : wr_only
   // two edges let the derived configuration outputs settle too
   task wr(input logic [31:0] w);
      wr_only(w);
      repeat (2) @(negedge clk);
   endtask : wr
   // always compares resp_valid, and of the other decision bits only those named in care
   task req_chk(input req_kind_e k, input logic [3:0] idx, input logic m,
                input logic [5:0] e, input logic [5:0] care);
      int i;
      logic [5:0] r;
      i = 0;
      while (req_ready_q !== 1'b1 && i < 40)
      begin
         @(negedge clk);
         i++;
      end
      req_valid = 1'b1;
      req_kind = k;
      req_idx = idx;
      req_tag_match = m;
      @(negedge clk);
      req_valid = 1'b0;
      // the decision stands one cycle only, so it is read before the next edge
      r = {resp_hit_q, resp_alloc_q, resp_l2_write_q, resp_dirty_q, resp_bus_write_q,
           resp_broadcast_q};
      `CHK("resp_valid", 1'b1, resp_valid_q)
      `CHK("resp_bits", e & care, r & care)
      @(negedge clk);
   endtask : req_chk
   initial
   begin
      #100000;
      num_errors++;
      complete_run();
   end
   initial
   begin
      rst_n = 1'b0;
      {spr_wr_en, req_valid, req_tag_match, nap_in, sleep_in} = 5'h00;
      spr_wdata = 32'h0000_0000;
      req_kind = K_LOAD;
      req_idx = 4'h0;
      repeat (2) @(negedge clk);
      `CHK("rdata_reset", 32'h0000_0000, spr_rdata_q)
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("ready", 1'b1, req_ready_q)
      wr(32'h7e00_7bff);
      `CHK("rdata_unused", 32'h0000_0000, spr_rdata_q)
      wr(32'h0101_8000);
      `CHK("rdata", 32'h0101_8000, spr_rdata_q)
      `CHK("pipelined", 1'b1, sram_pipelined_q)
      `CHK("hold", 2'b01, output_hold_select_q)
      `CHK("hold_0p8", 1'b1, hold_0p8ns_q)
      `CHK("dll_slow", 1'b1, dll_slow_taps_q)
      wr(32'h0082_0000);
      `CHK("pipelined", 1'b0, sram_pipelined_q)
      `CHK("hold", 2'b10, output_hold_select_q)
      `CHK("hold_0p8", 1'b0, hold_0p8ns_q)
      `CHK("dll_slow", 1'b0, dll_slow_taps_q)
      wr(32'h0000_0000);
      req_chk(K_LOAD, 4'h3, 1'b0, 6'h00, A);
      wr(EN);
      n = sram_model_inst.log_q.size();
      req_chk(K_LOAD, 4'h3, 1'b0, A, A);
      repeat (6) @(negedge clk);
      `CHK("beats", n + 4, sram_model_inst.log_q.size())
      for (int i = 0; i < 4; i++)
         `CHK("beat_addr", {4'h3, i[1:0]}, sram_model_inst.log_q[n + i])
      `CHK("sram_faults", 0, sram_model_inst.faults)
      req_chk(K_LOAD, 4'h3, 1'b1, H, H);
      req_chk(K_STORE, 4'h3, 1'b1, W | D, W | D | B);
      wr(EN | DO);
      req_chk(K_IFETCH, 4'h5, 1'b0, 6'h00, A);
      req_chk(K_LOAD, 4'h6, 1'b0, A, A);
      req_chk(K_IFETCH, 4'h3, 1'b1, H, H);
      wr(EN | DO | IO);
      req_chk(K_LOAD, 4'h7, 1'b0, 6'h00, A);
      req_chk(K_STORE, 4'h7, 1'b0, 6'h00, A);
      wr(EN | TS);
      req_chk(K_PUSH, 4'h3, 1'b1, W, W | B);
      req_chk(K_ZERO, 4'h8, 1'b0, 6'h00, Z);
      req_chk(K_STORE_SINGLE, 4'h9, 1'b0, 6'h00, B);
      wr(EN);
      req_chk(K_ZERO, 4'ha, 1'b0, Z, Z);
      req_chk(K_PUSH, 4'h3, 1'b1, B, W | B);
      wr(32'h0000_0000);
      wr(WT); // write-through chosen before enabling
      wr(WT | EN);
      req_chk(K_STORE, 4'h6, 1'b1, W | B, W | D | B);
      wr(32'h0000_0000);
      wr_only(INV); // cache disabled first
      n = 0;
      for (int i = 0; i < 40; i++)
      begin
         if (invalidate_busy_q === 1'b1)
         begin
            n++;
            `CHK("ready_inv", 1'b0, req_ready_q)
         end
         @(negedge clk);
      end
      `CHK("inv_cycles", 16, n)
      wr(EN);
      req_chk(K_LOAD, 4'h6, 1'b1, 6'h00, H);
      wr(CTL); // no quiesce snooping in this bench
      nap_in = 1'b1;
      repeat (3) @(negedge clk);
      `CHK("low_power_nap", 1'b1, cache_ram_low_power_out_q)
      nap_in = 1'b0;
      repeat (3) @(negedge clk);
      `CHK("low_power_wake", 1'b0, cache_ram_low_power_out_q)
      sleep_in = 1'b1;
      repeat (3) @(negedge clk);
      `CHK("low_power_sleep", 1'b1, cache_ram_low_power_out_q)
      wr(32'h0000_0000);
      @(negedge clk);
      `CHK("low_power_off", 1'b0, cache_ram_low_power_out_q)
      sleep_in = 1'b0;
      wr(EN | CTL | 32'h0101_8000);
      rst_n = 1'b0;
      @(negedge clk);
      `CHK("rdata_rst", 32'h0000_0000, spr_rdata_q)
      `CHK("pipelined_rst", 1'b0, sram_pipelined_q)
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("ready_rst", 1'b1, req_ready_q)
      complete_run();
   end
endmodule : l2_cache_mode_control_tb
